// >>> hw/rftc_map.vh
// Register offsets, field positions, argument limits and timing counts for the RF test command block.
// Assumes a 40 MHz bus clock and one aligned 32-bit word per register.
`ifndef RFTC_MAP_VH
`define RFTC_MAP_VH
// ==============================================
// Register byte offsets
`define RFTC_CMD 8'h00
`define RFTC_CHAN 8'h04
`define RFTC_POWER 8'h08
`define RFTC_RATE 8'h0C
`define RFTC_COUNT 8'h10
`define RFTC_GAP 8'h14
`define RFTC_FCTL 8'h18
`define RFTC_DUR 8'h1C
`define RFTC_SEQ 8'h20
`define RFTC_LEN 8'h24
`define RFTC_MODE 8'h28
`define RFTC_DATA 8'h2C
`define RFTC_STATUS 8'h30
`define RFTC_RX_TOTAL 8'h34
`define RFTC_RX_OK 8'h38
`define RFTC_RX_BAD 8'h3C
`define RFTC_RX_FCS 8'h40
// ==============================================
// Command bits
`define RFTC_CMD_FTX 0
`define RFTC_CMD_FRX 1
`define RFTC_CMD_WAVE 2
`define RFTC_CMD_STOP 3
// Mode bits
`define RFTC_MODE_PREAMBLE 0
`define RFTC_MODE_SCRAMBLER 1
`define RFTC_MODE_FORWARD 2
`define RFTC_MODE_MODULATED 3
`define RFTC_MODE_CONT 4
// Power register external amplifier bit
`define RFTC_POWER_EXT 8
// ==============================================
// Argument limits and stream markers
`define RFTC_INT_PWR_MAX 4'h7
`define RFTC_EXT_PWR_MIN 4'h2
`define RFTC_EXT_PWR_MAX 4'hF
`define RFTC_WAVE_RATE_MAX 8'h03
`define RFTC_LEN_MAX 11'h578
`define RFTC_ESC 8'h1B
`define RFTC_KEY_UC 8'h41
`define RFTC_KEY_LC 8'h61
`define RFTC_RATE_1M 8'h02
`define RFTC_RATE_2M 8'h04
`define RFTC_RATE_5M5 8'h0B
`define RFTC_RATE_11M 8'h16
// ==============================================
// Timing
`define RFTC_CLK_NS 25
`define RFTC_US_NS 1000
`define RFTC_CYC_PER_US (`RFTC_US_NS / `RFTC_CLK_NS)
`endif

// >>> hw/rftc_core.v
// RF test command block: AHB-Lite register slave plus frame, receive and wave test sequencing.
// Assumes a radio that acknowledges each frame with rf_tx_done and reports received frames by pulses.
//
// Functional notes
// - Frame power 0-7 internal, 2-15 external amplifier
// - Frame rate 2,4,11,22 mean 1,2,5.5,11
// - Send exactly count frames, 1 to 65535
// - Space frames by gap microseconds, 1-65535
// - Keep low frame control byte, upper zero
// - Byte holds subtype, type, protocol version
// - Sequence control passed unchanged, fragment/sequence split
// - Payload at most 1400, expect that many
// - Frame preamble 1 short; scrambler 1 off
// - No carrier sense before test frames
// - Receive test forwards data when flag set
// - Count four receive classes, report on stop
// - Wave modulated on 1, carrier on 0
// - Wave rate 0-3 mean 1,2,5.5,11
// - Wave preamble 1 long; scrambler 1 off; continuous
// - Wave power limited to 0-7
// - Stop halts any active test
`timescale 1ns/1ps
`include "rftc_map.vh"
module rftc_core (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // Radio transmit side
    output reg rf_tx_start,
    input wire rf_tx_done,
    output reg [7:0] rf_channel,
    output reg [3:0] rf_power,
    output reg [1:0] rf_rate_sel,
    output reg [15:0] rf_fctl,
    output reg [15:0] rf_duration,
    output reg [15:0] rf_seq,
    output reg [10:0] rf_len,
    output reg rf_short_preamble,
    output reg rf_scrambler_en,
    output reg rf_pl_valid,
    output reg [7:0] rf_pl_data,
    // Radio wave and receive side
    output reg rf_wave_en,
    output reg rf_wave_mod,
    output reg rf_wave_cont,
    output reg rf_rx_en,
    input wire rx_frame,
    input wire rx_good,
    input wire rx_bad,
    input wire rx_fcs_err,
    input wire rx_byte_valid,
    input wire [7:0] rx_byte,
    // Serial forwarding of received bytes
    output reg ser_valid,
    output reg [7:0] ser_data
);
    // ==============================================
    // States
    localparam [8:0] S_IDLE = 9'h001;
    localparam [8:0] S_ESC = 9'h002;
    localparam [8:0] S_KEY = 9'h004;
    localparam [8:0] S_LOAD = 9'h008;
    localparam [8:0] S_SEND = 9'h010;
    localparam [8:0] S_WAITTX = 9'h020;
    localparam [8:0] S_GAP = 9'h040;
    localparam [8:0] S_WAVE = 9'h080;
    localparam [8:0] S_RX = 9'h100;
    localparam [31:0] US_CYC_M1 = `RFTC_CYC_PER_US - 1;
    localparam [5:0] US_LAST = US_CYC_M1[5:0];

    // Frame rate decode: {valid, code}
    function [2:0] frate;
        input [7:0] r;
        begin
            case (r)
                `RFTC_RATE_1M: frate = 3'b100;
                `RFTC_RATE_2M: frate = 3'b101;
                `RFTC_RATE_5M5: frate = 3'b110;
                `RFTC_RATE_11M: frate = 3'b111;
                default: frate = 3'b000;
            endcase
        end
    endfunction

    // ==============================================
    // Registers
    reg [8:0] state_q;
    reg [7:0] chan_q, rate_q;
    reg [8:0] power_q;
    reg [15:0] count_q, gap_q, fctl_q, dur_q, seq_q;
    reg [10:0] len_q;
    reg [4:0] mode_q;
    reg [15:0] sent_q, gap_cnt_q;
    reg [10:0] byte_cnt_q;
    reg [5:0] us_cnt_q;
    reg arg_err_q, stats_rdy_q, key_err_q;
    reg [31:0] rxc_q [0:3];
    reg wr_pend_q;
    reg [7:0] addr_q;

    wire [2:0] fr_dec = frate(rate_q);
    wire ext_pa = power_q[`RFTC_POWER_EXT];
    wire fpwr_ok = ext_pa ? (power_q[3:0] >= `RFTC_EXT_PWR_MIN && power_q[3:0] <= `RFTC_EXT_PWR_MAX)
                          : (power_q[7:0] <= {4'h0, `RFTC_INT_PWR_MAX});
    wire ftx_ok = fpwr_ok && fr_dec[2] && count_q != 16'h0000 && gap_q != 16'h0000
                  && len_q <= `RFTC_LEN_MAX;
    wire wave_ok = power_q[7:0] <= {4'h0, `RFTC_INT_PWR_MAX} && rate_q <= `RFTC_WAVE_RATE_MAX;

    // ==============================================
    // Bus decode
    wire addr_ph = hsel && hready && htrans[1];
    wire wr_now = wr_pend_q;
    wire cmd_wr = wr_now && addr_q == `RFTC_CMD;
    wire data_wr = wr_now && addr_q == `RFTC_DATA;
    wire go_ftx = cmd_wr && hwdata[`RFTC_CMD_FTX] && state_q == S_IDLE;
    wire go_frx = cmd_wr && hwdata[`RFTC_CMD_FRX] && state_q == S_IDLE;
    wire go_wave = cmd_wr && hwdata[`RFTC_CMD_WAVE] && state_q == S_IDLE;
    wire stop = cmd_wr && hwdata[`RFTC_CMD_STOP];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            addr_q <= 8'h00;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            wr_pend_q <= addr_ph && hwrite;
            if (addr_ph) begin
                addr_q <= haddr[7:0];
            end
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Configuration writes, held stable while a test runs
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chan_q <= 8'h00;
            power_q <= 9'h000;
            rate_q <= 8'h00;
            count_q <= 16'h0000;
            gap_q <= 16'h0000;
            fctl_q <= 16'h0000;
            dur_q <= 16'h0000;
            seq_q <= 16'h0000;
            len_q <= 11'h000;
            mode_q <= 5'h00;
        end else if (wr_now && state_q == S_IDLE) begin
            case (addr_q)
                `RFTC_CHAN: chan_q <= hwdata[7:0];
                `RFTC_POWER: power_q <= hwdata[8:0];
                `RFTC_RATE: rate_q <= hwdata[7:0];
                `RFTC_COUNT: count_q <= hwdata[15:0];
                `RFTC_GAP: gap_q <= hwdata[15:0];
                `RFTC_FCTL: fctl_q <= {8'h00, hwdata[7:0]};
                `RFTC_DUR: dur_q <= hwdata[15:0];
                `RFTC_SEQ: seq_q <= hwdata[15:0];
                `RFTC_LEN: len_q <= hwdata[10:0];
                `RFTC_MODE: mode_q <= hwdata[4:0];
                default: chan_q <= chan_q;
            endcase
        end
    end

    // ==============================================
    // Read data, latched at the address phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (addr_ph && !hwrite) begin
            case (haddr[7:0])
                `RFTC_CHAN: hrdata <= {24'h000000, chan_q};
                `RFTC_POWER: hrdata <= {23'h000000, power_q};
                `RFTC_RATE: hrdata <= {24'h000000, rate_q};
                `RFTC_COUNT: hrdata <= {16'h0000, count_q};
                `RFTC_GAP: hrdata <= {16'h0000, gap_q};
                `RFTC_FCTL: hrdata <= {16'h0000, fctl_q};
                `RFTC_DUR: hrdata <= {16'h0000, dur_q};
                `RFTC_SEQ: hrdata <= {16'h0000, seq_q};
                `RFTC_LEN: hrdata <= {21'h000000, len_q};
                `RFTC_MODE: hrdata <= {27'h0000000, mode_q};
                `RFTC_STATUS: hrdata <= {sent_q, 4'h0, key_err_q, stats_rdy_q, arg_err_q, state_q};
                `RFTC_RX_TOTAL: hrdata <= rxc_q[0];
                `RFTC_RX_OK: hrdata <= rxc_q[1];
                `RFTC_RX_BAD: hrdata <= rxc_q[2];
                `RFTC_RX_FCS: hrdata <= rxc_q[3];
                default: hrdata <= 32'h00000000;
            endcase
        end
    end

    // ==============================================
    // Receive statistics
    wire [3:0] rx_ev = {rx_fcs_err, rx_bad, rx_good, rx_frame};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_rxc
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    rxc_q[gi] <= 32'h00000000;
                end else if (go_frx) begin
                    rxc_q[gi] <= 32'h00000000;
                end else if (state_q == S_RX && rx_ev[gi]) begin
                    rxc_q[gi] <= rxc_q[gi] + 32'h00000001;
                end
            end
        end
    endgenerate

    // ==============================================
    // Test sequencer
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= S_IDLE;
            sent_q <= 16'h0000;
            gap_cnt_q <= 16'h0000;
            byte_cnt_q <= 11'h000;
            us_cnt_q <= 6'h00;
            arg_err_q <= 1'b0;
            stats_rdy_q <= 1'b0;
            key_err_q <= 1'b0;
            rf_tx_start <= 1'b0;
            rf_pl_valid <= 1'b0;
            rf_pl_data <= 8'h00;
        end else begin
            rf_tx_start <= 1'b0;
            rf_pl_valid <= 1'b0;
            if (stop) begin
                stats_rdy_q <= (state_q == S_RX);
                state_q <= S_IDLE;
            end else begin
                case (state_q)
                    S_IDLE: begin
                        if (go_ftx) begin
                            arg_err_q <= !ftx_ok;
                            key_err_q <= 1'b0;
                            sent_q <= 16'h0000;
                            if (ftx_ok) begin
                                state_q <= S_ESC;
                            end
                        end else if (go_wave) begin
                            arg_err_q <= !wave_ok;
                            if (wave_ok) begin
                                state_q <= S_WAVE;
                            end
                        end else if (go_frx) begin
                            arg_err_q <= 1'b0;
                            stats_rdy_q <= 1'b0;
                            state_q <= S_RX;
                        end
                    end
                    S_ESC: begin
                        if (data_wr) begin
                            if (hwdata[7:0] == `RFTC_ESC) begin
                                state_q <= S_KEY;
                            end else begin
                                key_err_q <= 1'b1;
                            end
                        end
                    end
                    S_KEY: begin
                        if (data_wr) begin
                            if (hwdata[7:0] == `RFTC_KEY_UC || hwdata[7:0] == `RFTC_KEY_LC) begin
                                byte_cnt_q <= 11'h000;
                                state_q <= (len_q == 11'h000) ? S_SEND : S_LOAD;
                            end else begin
                                key_err_q <= 1'b1;
                                state_q <= S_ESC;
                            end
                        end
                    end
                    S_LOAD: begin
                        if (data_wr) begin
                            rf_pl_valid <= 1'b1;
                            rf_pl_data <= hwdata[7:0];
                            byte_cnt_q <= byte_cnt_q + 11'h001;
                            if (byte_cnt_q + 11'h001 == len_q) begin
                                state_q <= S_SEND;
                            end
                        end
                    end
                    S_SEND: begin
                        rf_tx_start <= 1'b1;
                        state_q <= S_WAITTX;
                    end
                    S_WAITTX: begin
                        if (rf_tx_done) begin
                            sent_q <= sent_q + 16'h0001;
                            gap_cnt_q <= gap_q;
                            us_cnt_q <= 6'h00;
                            state_q <= (sent_q + 16'h0001 == count_q) ? S_IDLE : S_GAP;
                        end
                    end
                    S_GAP: begin
                        if (us_cnt_q == US_LAST) begin
                            us_cnt_q <= 6'h00;
                            gap_cnt_q <= gap_cnt_q - 16'h0001;
                            if (gap_cnt_q == 16'h0001) begin
                                state_q <= S_SEND;
                            end
                        end else begin
                            us_cnt_q <= us_cnt_q + 6'h01;
                        end
                    end
                    S_WAVE: state_q <= S_WAVE;
                    S_RX: state_q <= S_RX;
                    default: state_q <= S_IDLE;
                endcase
            end
        end
    end

    // ==============================================
    // Radio settings and serial forwarding
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rf_channel <= 8'h00;
            rf_power <= 4'h0;
            rf_rate_sel <= 2'b00;
            rf_fctl <= 16'h0000;
            rf_duration <= 16'h0000;
            rf_seq <= 16'h0000;
            rf_len <= 11'h000;
            rf_short_preamble <= 1'b0;
            rf_scrambler_en <= 1'b1;
            rf_wave_en <= 1'b0;
            rf_wave_mod <= 1'b0;
            rf_wave_cont <= 1'b0;
            rf_rx_en <= 1'b0;
            ser_valid <= 1'b0;
            ser_data <= 8'h00;
        end else begin
            rf_channel <= chan_q;
            rf_power <= power_q[3:0];
            rf_fctl <= fctl_q;
            rf_duration <= dur_q;
            rf_seq <= seq_q;
            rf_len <= len_q;
            if (state_q == S_WAVE) begin
                rf_rate_sel <= rate_q[1:0];
                rf_short_preamble <= !mode_q[`RFTC_MODE_PREAMBLE];
            end else begin
                rf_rate_sel <= fr_dec[1:0];
                rf_short_preamble <= mode_q[`RFTC_MODE_PREAMBLE];
            end
            rf_scrambler_en <= !mode_q[`RFTC_MODE_SCRAMBLER];
            rf_wave_en <= state_q == S_WAVE && !stop;
            rf_wave_mod <= mode_q[`RFTC_MODE_MODULATED];
            rf_wave_cont <= mode_q[`RFTC_MODE_CONT];
            rf_rx_en <= state_q == S_RX && !stop;
            ser_valid <= state_q == S_RX && !stop && mode_q[`RFTC_MODE_FORWARD] && rx_byte_valid;
            ser_data <= rx_byte;
        end
    end
endmodule // rftc_core

// >>> tb/rftc_core_props.sv
// Concurrent checks on the ports of the RF test command block.
// Assumes rftc_map.vh on the include path; bound onto every rftc_core.
`timescale 1ns/1ps
`include "rftc_map.vh"
module rftc_core_props (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Bus
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    // Radio
    input wire rf_tx_start,
    input wire rf_tx_done,
    input wire [15:0] rf_fctl,
    input wire [15:0] rf_seq,
    input wire [3:0] rf_power,
    input wire rf_wave_en,
    input wire rf_rx_en,
    input wire rx_byte_valid,
    input wire [7:0] rx_byte,
    input wire ser_valid,
    input wire [7:0] ser_data
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ========
    // Sequences
    sequence cmd_wr;
        hsel && hready && htrans[1] && hwrite && haddr[7:0] == `RFTC_CMD;
    endsequence
    sequence stop_wr;
        cmd_wr ##1 hwdata[`RFTC_CMD_STOP];
    endsequence
    // ========
    // Assertions
    bus_okay_a: assert property ($past(hresetn) |-> hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    fctl_upper_a: assert property (rf_fctl[15:8] == 8'h00)
        else $error("frame control upper byte not zero");
    start_pulse_a: assert property (rf_tx_start |=> !rf_tx_start)
        else $error("frame start longer than one cycle");
    gap_quiet_a: assert property (rf_tx_done |=> !rf_tx_start [*8])
        else $error("frame started inside the gap");
    stop_halts_a: assert property (stop_wr |-> ##2 (!rf_wave_en && !rf_rx_en))
        else $error("test still active after stop");
    fwd_data_a: assert property (ser_valid |-> rf_rx_en && $past(rx_byte_valid) && ser_data == $past(rx_byte))
        else $error("forwarded byte without cause");
    wave_power_a: assert property (rf_wave_en |-> rf_power <= 4'h7)
        else $error("wave power out of range");
    cfg_stable_a: assert property (rf_tx_start |-> $stable(rf_seq) && $stable(rf_fctl))
        else $error("frame fields changed during test");
    mode_excl_a: assert property (rf_wave_en |-> !rf_rx_en && !rf_tx_start)
        else $error("two tests active at once");
endmodule // rftc_core_props
bind rftc_core rftc_core_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .rf_tx_start(rf_tx_start), .rf_tx_done(rf_tx_done), .rf_fctl(rf_fctl), .rf_seq(rf_seq), .rf_power(rf_power),
    .rf_wave_en(rf_wave_en), .rf_rx_en(rf_rx_en), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .ser_valid(ser_valid), .ser_data(ser_data));

// >>> tb/rftc_radio_model.sv
// Radio model: answers each frame start with a done pulse after a set delay.
// Assumes the bench picks the delay; counts frames sent.
`timescale 1ns/1ps
module rftc_radio_model (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Radio handshake
    input wire rf_tx_start,
    input wire [7:0] done_delay,
    output reg rf_tx_done,
    output reg [15:0] n_frames
);
    reg [7:0] wait_q;
    reg busy_q;
    // ========
    // Frame airtime
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_q <= 8'h00;
            busy_q <= 1'b0;
            rf_tx_done <= 1'b0;
            n_frames <= 16'h0000;
        end else begin
            rf_tx_done <= 1'b0;
            if (rf_tx_start) begin
                busy_q <= 1'b1;
                wait_q <= done_delay;
                n_frames <= n_frames + 16'h0001;
            end else if (busy_q) begin
                if (wait_q == 8'h00) begin
                    rf_tx_done <= 1'b1;
                    busy_q <= 1'b0;
                end else begin
                    wait_q <= wait_q - 8'h01;
                end
            end
        end
    end
endmodule // rftc_radio_model

// >>> tb/tb_top.sv
// Self-checking bench for the RF test command block over AHB-Lite.
// Assumes rftc_map.vh on the include path and a zero-wait slave.
`timescale 1ns/1ps
`include "rftc_map.vh"
module tb_top;
    reg hclk = 1'b0;
    reg hresetn = 1'b0;
    reg hsel = 1'b0;
    reg [31:0] haddr = 32'h0;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 1'b0;
    reg [31:0] hwdata = 32'h0;
    reg [3:0] rx_pulse = 4'h0;
    reg rx_byte_valid = 1'b0;
    reg [7:0] rx_byte = 8'h00;
    reg [7:0] done_delay = 8'h00;
    reg [31:0] q;
    wire hready, hresp, rf_tx_start, rf_tx_done, rf_short_preamble, rf_scrambler_en, rf_pl_valid;
    wire rf_wave_en, rf_wave_mod, rf_wave_cont, rf_rx_en, ser_valid;
    wire [31:0] hrdata;
    wire [7:0] rf_channel, rf_pl_data, ser_data;
    wire [3:0] rf_power;
    wire [1:0] rf_rate_sel;
    wire [15:0] rf_fctl, rf_duration, rf_seq, frames;
    wire [10:0] rf_len;
    integer n_mismatch = 0, cmp_count = 0, pl_cnt = 0, ser_cnt = 0, since_done = 0, gap_seen = 0, i;
    always #12.5 hclk = ~hclk;
    // ========
    // Design and radio
    rftc_core u_rftc_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
        .hresp(hresp), .rf_tx_start(rf_tx_start), .rf_tx_done(rf_tx_done), .rf_channel(rf_channel),
        .rf_power(rf_power), .rf_rate_sel(rf_rate_sel), .rf_fctl(rf_fctl), .rf_duration(rf_duration),
        .rf_seq(rf_seq), .rf_len(rf_len), .rf_short_preamble(rf_short_preamble), .rf_scrambler_en(rf_scrambler_en),
        .rf_pl_valid(rf_pl_valid), .rf_pl_data(rf_pl_data), .rf_wave_en(rf_wave_en), .rf_wave_mod(rf_wave_mod),
        .rf_wave_cont(rf_wave_cont), .rf_rx_en(rf_rx_en), .rx_frame(rx_pulse[0]), .rx_good(rx_pulse[1]),
        .rx_bad(rx_pulse[2]), .rx_fcs_err(rx_pulse[3]), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
        .ser_valid(ser_valid), .ser_data(ser_data));
    rftc_radio_model u_rftc_radio_model (.hclk(hclk), .hresetn(hresetn), .rf_tx_start(rf_tx_start),
        .done_delay(done_delay), .rf_tx_done(rf_tx_done), .n_frames(frames));
    always @(posedge hclk) begin
        since_done <= rf_tx_done ? 0 : since_done + 1;
        if (rf_tx_start) gap_seen <= since_done;
        if (rf_pl_valid) pl_cnt <= pl_cnt + 1;
        if (ser_valid) ser_cnt <= ser_cnt + 1;
    end
    // ========
    // Shared tasks
    task close_out;
        begin
            if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task wait_rdy;
        integer n;
        begin
            n = 0;
            @(posedge hclk);
            while (hready !== 1'b1) begin
                n = n + 1;
                if (n > 50) begin
                    n_mismatch = n_mismatch + 1;
                    close_out;
                end
                @(posedge hclk);
            end
        end
    endtask
    task bus(input wr, input [7:0] a, input [31:0] d);
        begin
            hsel <= 1'b1;
            haddr <= {24'h0, a};
            hwrite <= wr;
            htrans <= 2'h2;
            wait_rdy;
            htrans <= 2'h0;
            hsel <= 1'b0;
            hwdata <= d;
            wait_rdy;
            q = hrdata;
        end
    endtask
    task rdc(input [7:0] a, input [31:0] e);
        begin
            bus(1'b0, a, 32'h0);
            chk(q, e);
        end
    endtask
    // ========
    // Scenarios
    task sc_reset;
        begin
            chk(rf_scrambler_en, 32'h1);
            rdc(`RFTC_STATUS, 32'h1);
            rdc(8'h80, 32'h0);
        end
    endtask
    task sc_frame;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                bus(1'b1, `RFTC_RATE, (32'h160B0402 >> (8 * i)) & 32'h000000FF);
                repeat (2) @(posedge hclk);
                chk(rf_rate_sel, i);
            end
            bus(1'b1, `RFTC_CHAN, 32'h5);
            bus(1'b1, `RFTC_COUNT, 32'h2);
            bus(1'b1, `RFTC_GAP, 32'h1);
            bus(1'b1, `RFTC_FCTL, 32'hABCD);
            bus(1'b1, `RFTC_SEQ, 32'h1234);
            bus(1'b1, `RFTC_LEN, 32'h3);
            bus(1'b1, `RFTC_MODE, 32'h1);
            bus(1'b1, `RFTC_POWER, 32'h101);
            bus(1'b1, `RFTC_CMD, 32'h1);
            bus(1'b0, `RFTC_STATUS, 32'h0);
            chk({q[9], q[0]}, 32'h3);
            bus(1'b1, `RFTC_POWER, 32'h10F);
            done_delay <= 8'h05;
            rx_pulse <= 4'h1;
            bus(1'b1, `RFTC_CMD, 32'h1);
            bus(1'b1, `RFTC_DATA, 32'h20);
            bus(1'b1, `RFTC_DATA, 32'h1B);
            bus(1'b1, `RFTC_DATA, 32'h61);
            for (i = 0; i < 3; i = i + 1) bus(1'b1, `RFTC_DATA, 32'h30 + i);
            chk({rf_fctl, rf_seq}, 32'h00CD1234);
            chk({rf_power, rf_short_preamble, rf_scrambler_en}, 32'h3F);
            i = 0;
            q = 32'h0;
            while (q[0] !== 1'b1 && i < 400) begin
                bus(1'b0, `RFTC_STATUS, 32'h0);
                i = i + 1;
            end
            rx_pulse <= 4'h0;
            chk(i < 400, 32'h1);
            if (i >= 400) close_out;
            chk(q[11], 32'h1);
            chk({q[31:16], frames}, 32'h00020002);
            chk(pl_cnt, 32'h3);
            chk(gap_seen >= 40 && gap_seen <= 45, 32'h1);
            bus(1'b1, `RFTC_CMD, 32'h8);
        end
    endtask
    task sc_wave;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                bus(1'b1, `RFTC_POWER, 32'h7);
                bus(1'b1, `RFTC_RATE, i);
                bus(1'b1, `RFTC_MODE, {27'h0, 1'b1, i[0], 1'b0, i[0], i[1]});
                bus(1'b1, `RFTC_CMD, 32'h4);
                repeat (2) @(posedge hclk);
                chk({rf_wave_en, rf_wave_mod, rf_wave_cont, rf_rate_sel}, {27'h0, 1'b1, i[0], 1'b1, i[1:0]});
                chk({rf_short_preamble, rf_scrambler_en, rf_power}, {26'h0, !i[1], !i[0], 4'h7});
                bus(1'b1, `RFTC_CMD, 32'h8);
                repeat (2) @(posedge hclk);
                chk(rf_wave_en, 32'h0);
            end
            bus(1'b1, `RFTC_POWER, 32'h8);
            bus(1'b1, `RFTC_CMD, 32'h4);
            bus(1'b0, `RFTC_STATUS, 32'h0);
            chk({q[9], q[7], rf_wave_en}, 32'h4);
        end
    endtask
    task sc_rx;
        begin
            bus(1'b1, `RFTC_MODE, 32'h4);
            bus(1'b1, `RFTC_CMD, 32'h2);
            for (i = 0; i < 3; i = i + 1) begin
                rx_pulse <= {i == 1, i == 0, i < 2, 1'b1};
                rx_byte_valid <= (i == 0);
                rx_byte <= 8'hA5;
                @(posedge hclk);
            end
            rx_pulse <= 4'h0;
            rx_byte_valid <= 1'b0;
            repeat (2) @(posedge hclk);
            chk(ser_cnt, 32'h1);
            bus(1'b1, `RFTC_CMD, 32'h8);
            bus(1'b0, `RFTC_STATUS, 32'h0);
            chk({q[10], rf_rx_en}, 32'h2);
            for (i = 0; i < 4; i = i + 1) rdc(`RFTC_RX_TOTAL + 4 * i, (32'h01010203 >> (8 * i)) & 32'h000000FF);
            bus(1'b1, `RFTC_MODE, 32'h0);
            bus(1'b1, `RFTC_CMD, 32'h2);
            rdc(`RFTC_RX_TOTAL, 32'h0);
            rx_byte_valid <= 1'b1;
            @(posedge hclk);
            rx_byte_valid <= 1'b0;
            repeat (2) @(posedge hclk);
            chk(ser_cnt, 32'h1);
            bus(1'b1, `RFTC_CMD, 32'h8);
        end
    endtask
    // ========
    // Main sequence
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        sc_reset;
        sc_frame;
        sc_wave;
        sc_rx;
        close_out;
    end
    initial begin
        #2500000;
        n_mismatch = n_mismatch + 1;
        close_out;
    end
endmodule // tb_top
